// file: common/mea_consts.svh
// constants of the meter energy accumulator block
`ifndef MEA_CONSTS_SVH
`define MEA_CONSTS_SVH
// ---------------------------------------------------------------
// volume resolution codes and product divisors
// ---------------------------------------------------------------
`define MEA_RES_0_001   2'h0
`define MEA_RES_0_01    2'h1
`define MEA_RES_0_1     2'h2
`define MEA_RES_1       2'h3
`define MEA_DIV_0_001   64'h00000000000f4240
`define MEA_DIV_0_01    64'h0000000000002710
`define MEA_DIV_0_1     64'h0000000000000064
`define MEA_DIV_1       64'h0000000000000001
// ---------------------------------------------------------------
// performance coefficient limits and averaging window
// ---------------------------------------------------------------
`define MEA_PERF_MAX    8'hc7
`define MEA_PERF_SCALE  52'h000000000000a
`define MEA_DAYS_MIN    5'h05
`define MEA_DAYS_MAX    5'h1e
`define MEA_DAYS_DEF    5'h07
`define MEA_WH_PER_KWH  32'h000003e8
`define MEA_WH_PER_MWH  32'h000f4240
`define MEA_SEC_PER_MIN 32'h0000003c
`endif

// file: common/mea_pkg.sv
// types of the meter energy accumulator block
package mea_pkg;
  typedef struct packed {
    logic        [15:0] first_flow_volume;    // volume increment, resolution units
    logic        [15:0] second_flow_volume;
    logic signed [15:0] inlet_temperature;    // 0.01 degC
    logic signed [15:0] outlet_temperature;
    logic signed [15:0] third_temperature;
  } mea_meas_t;
  typedef struct packed {
    logic inlet_bad;
    logic outlet_bad;
    logic third_bad;
  } mea_fault_t;
  typedef struct packed {
    logic        [1:0]  vol_res;
    logic signed [15:0] outlet_reference_temperature;
    logic        [15:0] heat_coef;
    logic               elec_unit_mwh;
    logic        [15:0] elec_pulse_weight;
    logic        [4:0]  perf_days;
  } mea_cfg_t;
endpackage : mea_pkg

// file: design/mea_accumulators.sv
// accumulation datapath: volume-temperature sums, outlet energy, performance coefficient
`timescale 1ns/1ps
`default_nettype none
`include "mea_consts.svh"
module mea_accumulators (
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  input  wire logic             INTEG_STB,
  input  wire mea_pkg::mea_meas_t  MEAS,
  input  wire mea_pkg::mea_fault_t FAULT,
  input  wire mea_pkg::mea_cfg_t   CFG,
  input  wire logic [31:0]      HEAT_WH_INC,
  input  wire logic             ELEC_PULSE,
  input  wire logic             MIN_TICK,
  input  wire logic             DAY_TICK,
  input  wire logic             MONTH_TICK,
  input  wire logic             YEAR_TICK,
  output logic      [47:0]      INLET_TEMP_VOLUME_SUM,
  output logic      [47:0]      OUTLET_TEMP_VOLUME_SUM,
  output logic      [47:0]      THIRD_TEMP_FLOW1_SUM,
  output logic      [47:0]      THIRD_TEMP_FLOW2_SUM,
  output logic      [63:0]      DISCOUNT_HEAT_ENERGY,
  output logic      [63:0]      SURCHARGE_HEAT_ENERGY,
  output logic      [7:0]       PERFORMANCE_COEFFICIENT,
  output logic      [7:0]       MONTHLY_PERFORMANCE_COEFFICIENT,
  output logic      [7:0]       SEASONAL_PERFORMANCE_COEFFICIENT,
  output logic      [4:0]       PERF_PERIOD_DAYS,
  output logic      [31:0]      CURRENT_POWER_W
);
  import mea_pkg::*;
  localparam int NDAYS = 30;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // unsigned product, a negative temperature adds nothing
  function automatic logic [31:0] vt_prod(input logic [15:0] v, input logic signed [15:0] t);
    vt_prod = t[15] ? 32'h0 : 32'(v) * 32'({1'b0, t[14:0]});
  endfunction : vt_prod
  function automatic logic [47:0] scale(input logic [63:0] acc, input logic [1:0] res);
    logic [63:0] q;
    q = 64'h0;
    unique case (res)
      `MEA_RES_0_001: q = acc / `MEA_DIV_0_001;
      `MEA_RES_0_01:  q = acc / `MEA_DIV_0_01;
      `MEA_RES_0_1:   q = acc / `MEA_DIV_0_1;
      `MEA_RES_1:     q = acc / `MEA_DIV_1;
    endcase
    scale = q[47:0];
  endfunction : scale
  function automatic logic [7:0] perf_ratio(input logic [47:0] heat, input logic [47:0] elec);
    logic [51:0] q;
    q = 52'h0;
    if (elec != 48'h0)
      q = ({4'h0, heat} * `MEA_PERF_SCALE) / {4'h0, elec};
    perf_ratio = (q > {44'h0, `MEA_PERF_MAX}) ? `MEA_PERF_MAX : q[7:0];
  endfunction : perf_ratio

  // ---------------------------------------------------------------
  // volume-temperature and outlet energy accumulators
  // ---------------------------------------------------------------
  logic [63:0] sum_q [4];
  logic [63:0] sum_d [4];
  logic [31:0] prod [4];
  logic [63:0] disc_q, disc_d, surch_q, surch_d;
  logic signed [16:0] ref_diff;
  logic        [15:0] ref_mag;
  logic               heat_ok;
  logic [47:0]        outlet_inc;

  always_comb begin
    prod[0] = vt_prod(MEAS.first_flow_volume, MEAS.inlet_temperature);
    prod[1] = vt_prod(MEAS.first_flow_volume, MEAS.outlet_temperature);
    prod[2] = vt_prod(MEAS.first_flow_volume, MEAS.third_temperature);
    prod[3] = vt_prod(MEAS.second_flow_volume, MEAS.third_temperature);
    sum_d[0] = sum_q[0] + ((INTEG_STB && !FAULT.inlet_bad)  ? {32'h0, prod[0]} : 64'h0);
    sum_d[1] = sum_q[1] + ((INTEG_STB && !FAULT.outlet_bad) ? {32'h0, prod[1]} : 64'h0);
    sum_d[2] = sum_q[2] + ((INTEG_STB && !FAULT.third_bad)  ? {32'h0, prod[2]} : 64'h0);
    sum_d[3] = sum_q[3] + ((INTEG_STB && !FAULT.third_bad)  ? {32'h0, prod[3]} : 64'h0);
    ref_diff = 17'(CFG.outlet_reference_temperature) - 17'(MEAS.outlet_temperature);
    ref_mag  = ref_diff[16] ? 16'(-ref_diff) : ref_diff[15:0];
    heat_ok  = INTEG_STB && !FAULT.inlet_bad && !FAULT.outlet_bad
               && (MEAS.inlet_temperature != MEAS.outlet_temperature);
    outlet_inc = 48'(MEAS.first_flow_volume) * 48'(ref_mag) * 48'(CFG.heat_coef);
    disc_d  = disc_q  + ((heat_ok && !ref_diff[16] && ref_diff != 17'h0) ? {16'h0, outlet_inc} : 64'h0);
    surch_d = surch_q + ((heat_ok && ref_diff[16]) ? {16'h0, outlet_inc} : 64'h0);
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        sum_q[i] <= 64'h0;
      end
      disc_q  <= 64'h0;
      surch_q <= 64'h0;
    end else begin
      sum_q   <= sum_d;
      disc_q  <= disc_d;
      surch_q <= surch_d;
    end
  end

  // ---------------------------------------------------------------
  // daily, monthly and yearly energy sums
  // ---------------------------------------------------------------
  logic [39:0] heat_day_q [NDAYS];
  logic [39:0] elec_day_q [NDAYS];
  logic [39:0] heat_day_d [NDAYS];
  logic [39:0] elec_day_d [NDAYS];
  logic [39:0] heat_today_q, heat_today_d, elec_today_q, elec_today_d;
  logic [47:0] heat_mon_q, heat_mon_d, elec_mon_q, elec_mon_d;
  logic [47:0] heat_yr_q, heat_yr_d, elec_yr_q, elec_yr_d;
  logic [4:0]  seen_q, seen_d, period;
  logic [31:0] heat_inc, elec_inc, min_wh_q, min_wh_d;
  logic [47:0] win_heat, win_elec;
  logic        win_ok;

  always_comb begin
    elec_inc = ELEC_PULSE ? 32'(CFG.elec_pulse_weight) * (CFG.elec_unit_mwh ? `MEA_WH_PER_MWH : `MEA_WH_PER_KWH) : 32'h0;
    heat_inc = INTEG_STB ? HEAT_WH_INC : 32'h0;
    period = (CFG.perf_days < `MEA_DAYS_MIN) ? `MEA_DAYS_MIN :
             (CFG.perf_days > `MEA_DAYS_MAX) ? `MEA_DAYS_MAX : CFG.perf_days;
    heat_day_d   = heat_day_q;
    elec_day_d   = elec_day_q;
    seen_d       = seen_q;
    heat_today_d = heat_today_q + {8'h0, heat_inc};
    elec_today_d = elec_today_q + {8'h0, elec_inc};
    if (DAY_TICK) begin
      for (int i = NDAYS - 1; i > 0; i--) begin
        heat_day_d[i] = heat_day_q[i-1];
        elec_day_d[i] = elec_day_q[i-1];
      end
      heat_day_d[0] = heat_today_q;
      elec_day_d[0] = elec_today_q;
      heat_today_d  = {8'h0, heat_inc};
      elec_today_d  = {8'h0, elec_inc};
      seen_d        = (seen_q == `MEA_DAYS_MAX) ? seen_q : seen_q + 5'h1;
    end
    heat_mon_d = MONTH_TICK ? {16'h0, heat_inc} : heat_mon_q + {16'h0, heat_inc};
    elec_mon_d = MONTH_TICK ? {16'h0, elec_inc} : elec_mon_q + {16'h0, elec_inc};
    heat_yr_d  = YEAR_TICK  ? {16'h0, heat_inc} : heat_yr_q  + {16'h0, heat_inc};
    elec_yr_d  = YEAR_TICK  ? {16'h0, elec_inc} : elec_yr_q  + {16'h0, elec_inc};
    min_wh_d   = MIN_TICK   ? elec_inc : min_wh_q + elec_inc;
    win_heat = 48'h0;
    win_elec = 48'h0;
    win_ok   = (seen_q >= period);
    for (int i = 0; i < NDAYS; i++) begin
      if (5'(i) < period) begin
        win_heat = win_heat + {8'h0, heat_day_q[i]};
        win_elec = win_elec + {8'h0, elec_day_q[i]};
        if (heat_day_q[i] == 40'h0 || elec_day_q[i] == 40'h0)
          win_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NDAYS; i++) begin
        heat_day_q[i] <= 40'h0;
        elec_day_q[i] <= 40'h0;
      end
      heat_today_q <= 40'h0;
      elec_today_q <= 40'h0;
      heat_mon_q   <= 48'h0;
      elec_mon_q   <= 48'h0;
      heat_yr_q    <= 48'h0;
      elec_yr_q    <= 48'h0;
      min_wh_q     <= 32'h0;
      seen_q       <= 5'h0;
    end else begin
      heat_day_q   <= heat_day_d;
      elec_day_q   <= elec_day_d;
      heat_today_q <= heat_today_d;
      elec_today_q <= elec_today_d;
      heat_mon_q   <= heat_mon_d;
      elec_mon_q   <= elec_mon_d;
      heat_yr_q    <= heat_yr_d;
      elec_yr_q    <= elec_yr_d;
      min_wh_q     <= min_wh_d;
      seen_q       <= seen_d;
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      INLET_TEMP_VOLUME_SUM            <= 48'h0;
      OUTLET_TEMP_VOLUME_SUM           <= 48'h0;
      THIRD_TEMP_FLOW1_SUM             <= 48'h0;
      THIRD_TEMP_FLOW2_SUM             <= 48'h0;
      DISCOUNT_HEAT_ENERGY             <= 64'h0;
      SURCHARGE_HEAT_ENERGY            <= 64'h0;
      PERFORMANCE_COEFFICIENT          <= 8'h0;
      MONTHLY_PERFORMANCE_COEFFICIENT  <= 8'h0;
      SEASONAL_PERFORMANCE_COEFFICIENT <= 8'h0;
      PERF_PERIOD_DAYS                 <= `MEA_DAYS_DEF;
      CURRENT_POWER_W                  <= 32'h0;
    end else begin
      INLET_TEMP_VOLUME_SUM  <= scale(sum_q[0], CFG.vol_res);
      OUTLET_TEMP_VOLUME_SUM <= scale(sum_q[1], CFG.vol_res);
      THIRD_TEMP_FLOW1_SUM   <= scale(sum_q[2], CFG.vol_res);
      THIRD_TEMP_FLOW2_SUM   <= scale(sum_q[3], CFG.vol_res);
      DISCOUNT_HEAT_ENERGY   <= disc_q;
      SURCHARGE_HEAT_ENERGY  <= surch_q;
      PERFORMANCE_COEFFICIENT <= win_ok ? perf_ratio(win_heat, win_elec) : 8'h0;
      if (MONTH_TICK) begin
        MONTHLY_PERFORMANCE_COEFFICIENT <= perf_ratio(heat_mon_q, elec_mon_q);
      end
      if (YEAR_TICK) begin
        SEASONAL_PERFORMANCE_COEFFICIENT <= perf_ratio(heat_yr_q, elec_yr_q);
      end
      PERF_PERIOD_DAYS <= period;
      if (MIN_TICK) begin
        CURRENT_POWER_W <= 32'(min_wh_q * `MEA_SEC_PER_MIN);
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_inlet_step;
    INTEG_STB && !FAULT.inlet_bad && prod[0] != 32'h0;
  endsequence
  sequence s_shown_next;
    ##1 1'b1 ##1 INLET_TEMP_VOLUME_SUM == scale($past(sum_q[0]), $past(CFG.vol_res));
  endsequence

  AST_INLET_ADD: assert property (s_inlet_step |=> sum_q[0] == $past(sum_q[0]) + {32'h0, $past(prod[0])})
    else $error("inlet sum did not add product");
  AST_INLET_SHOWN: assert property (s_inlet_step |-> s_shown_next)
    else $error("inlet sum output not scaled");
  AST_OUTLET_FAULT: assert property (FAULT.outlet_bad |=> sum_q[1] == $past(sum_q[1]))
    else $error("outlet sum moved under fault");
  AST_THIRD_PAIR: assert property (INTEG_STB && !FAULT.third_bad |=>
    sum_q[3] - $past(sum_q[3]) == {32'h0, $past(prod[3])}) else $error("third flow2 sum wrong");
  AST_NO_TRIGGER: assert property (!INTEG_STB |=> $stable(sum_q[2]) && $stable(disc_q))
    else $error("sum moved without integration");
  AST_EQUAL_TEMPS: assert property (MEAS.inlet_temperature == MEAS.outlet_temperature
    |=> $stable(disc_q) && $stable(surch_q)) else $error("outlet energy moved at equal temps");
  AST_DISC_ZERO: assert property (ref_diff[16] || ref_diff == 17'h0 |=> $stable(disc_q))
    else $error("discount added with non-positive difference");
  AST_SURCH_ADD: assert property (heat_ok && ref_diff[16] && outlet_inc != 48'h0 |=> surch_q > $past(surch_q))
    else $error("surcharge did not grow");
  AST_PERF_RANGE: assert property (PERFORMANCE_COEFFICIENT <= `MEA_PERF_MAX)
    else $error("coefficient above limit");
  AST_PERF_MISSING: assert property (!win_ok |=> PERFORMANCE_COEFFICIENT == 8'h0)
    else $error("coefficient not zero on missing data");
  AST_PERIOD: assert property (##1 PERF_PERIOD_DAYS >= `MEA_DAYS_MIN && PERF_PERIOD_DAYS <= `MEA_DAYS_MAX)
    else $error("averaging period out of range");
  AST_DAY_SHIFT: assert property (DAY_TICK |=> heat_day_q[0] == $past(heat_today_q)
    && elec_day_q[1] == $past(elec_day_q[0])) else $error("day shift wrong");
endmodule : mea_accumulators
`default_nettype wire

// file: dv/mea_front_end.sv
// measurement front end model feeding volume increments and temperatures
`timescale 1ns/1ps
`default_nettype none
module mea_front_end (
  input  wire logic             clk_sys,
  output var  mea_pkg::mea_meas_t meas,
  output var  logic             integ_stb
);
  import mea_pkg::*;
  // idle before the first measurement
  initial begin
    meas      = '0;
    integ_stb = 1'b0;
  end
  // one measurement per strobe; released fields invert
  task automatic send(input mea_meas_t m, input logic last);
    meas      <= m;
    integ_stb <= 1'b1;
    @(posedge clk_sys);
    if (last) begin
      integ_stb <= 1'b0;
      meas      <= ~m;
    end
  endtask : send
endmodule : mea_front_end
`default_nettype wire

// file: dv/mea_accumulators_test.sv
// self-checking bench of the meter energy accumulator block
`timescale 1ns/1ps
`default_nettype none
`include "mea_consts.svh"
module mea_accumulators_test;
  import mea_pkg::*;
  logic        clk_sys, rst, integ_stb, elec_pulse, min_tick, day_tick, month_tick, year_tick;
  logic [31:0] heat_wh_inc, power_w;
  logic [47:0] sum_in, sum_out, sum_3a, sum_3b;
  logic [63:0] dis_o, sur_o;
  logic [7:0]  perf_now, perf_mon, perf_yr;
  logic [4:0]  days_o;
  mea_meas_t   meas, m;
  mea_fault_t  fault;
  mea_cfg_t    cfg;
  longint      fin [4];
  longint      dis_m, sur_m, th, tp;
  int          hd [10];
  int          pd [10];
  int          err_count, comparisons;
  // -------------------------------------------------
  // design, front end and clock
  // -------------------------------------------------
  mea_front_end fe (.clk_sys(clk_sys), .meas(meas), .integ_stb(integ_stb));
  mea_accumulators dut (.CLK_SYS(clk_sys), .RST(rst), .INTEG_STB(integ_stb), .MEAS(meas), .FAULT(fault),
    .CFG(cfg), .HEAT_WH_INC(heat_wh_inc), .ELEC_PULSE(elec_pulse), .MIN_TICK(min_tick), .DAY_TICK(day_tick),
    .MONTH_TICK(month_tick), .YEAR_TICK(year_tick), .INLET_TEMP_VOLUME_SUM(sum_in),
    .OUTLET_TEMP_VOLUME_SUM(sum_out), .THIRD_TEMP_FLOW1_SUM(sum_3a), .THIRD_TEMP_FLOW2_SUM(sum_3b),
    .DISCOUNT_HEAT_ENERGY(dis_o), .SURCHARGE_HEAT_ENERGY(sur_o), .PERFORMANCE_COEFFICIENT(perf_now),
    .MONTHLY_PERFORMANCE_COEFFICIENT(perf_mon), .SEASONAL_PERFORMANCE_COEFFICIENT(perf_yr),
    .PERF_PERIOD_DAYS(days_o), .CURRENT_POWER_W(power_w));
  always #25 clk_sys = ~clk_sys;
  // -------------------------------------------------
  // helpers and expectations
  // -------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // one-cycle strobe: 0 energy pulse, 1 minute tick, 2 day tick
  task automatic pulse(input int sel);
    case (sel)
      0: elec_pulse <= 1'b1;
      1: min_tick <= 1'b1;
      default: day_tick <= 1'b1;
    endcase
    @(posedge clk_sys);
    {elec_pulse, min_tick, day_tick} <= 3'h0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  function automatic longint pos(input longint t);
    return (t > 0) ? t : 0;
  endfunction : pos
  function automatic logic [63:0] div(input logic [1:0] r);
    case (r)
      2'h0: return `MEA_DIV_0_001;
      2'h1: return `MEA_DIV_0_01;
      2'h2: return `MEA_DIV_0_1;
      default: return `MEA_DIV_1;
    endcase
  endfunction : div
  function automatic logic [7:0] perf_of(input longint h, input longint e);
    longint q;
    q = (e == 0) ? 0 : 10 * h / e;
    return (q > 199) ? 8'hc7 : 8'(q);
  endfunction : perf_of
  // reference sums of one integration
  task automatic integ(input mea_meas_t mm, input logic last);
    longint va, vb, tin, tout, tth, tref;
    va = mm.first_flow_volume;
    vb = mm.second_flow_volume;
    tin = mm.inlet_temperature;
    tout = mm.outlet_temperature;
    tth = mm.third_temperature;
    tref = cfg.outlet_reference_temperature;
    if (!fault.inlet_bad) fin[0] += va * pos(tin);
    if (!fault.outlet_bad) fin[1] += va * pos(tout);
    if (!fault.third_bad) begin
      fin[2] += va * pos(tth);
      fin[3] += vb * pos(tth);
    end
    if (!fault.inlet_bad && !fault.outlet_bad && tin != tout) begin
      if (tref > tout) dis_m += va * (tref - tout) * longint'(cfg.heat_coef);
      if (tout > tref) sur_m += va * (tout - tref) * longint'(cfg.heat_coef);
    end
    fe.send(mm, last);
    if (last) tick(1);
  endtask : integ
  task automatic rand_meas(output mea_meas_t mm);
    mm.first_flow_volume  = 16'($urandom_range(0, 1000));
    mm.second_flow_volume = 16'($urandom_range(0, 1000));
    mm.inlet_temperature  = 16'($urandom_range(7000, 12000));
    mm.outlet_temperature = 16'($urandom_range(2000, 6999));
    mm.third_temperature  = 16'($urandom_range(0, 6000) - 1000);
  endtask : rand_meas
  // all sums sampled in one step
  task automatic chk_all(input logic [1:0] r);
    chk(64'(sum_in), 64'(fin[0]) / div(r), "inlet sum");
    chk(64'(sum_out), 64'(fin[1]) / div(r), "outlet sum");
    chk(64'(sum_3a), 64'(fin[2]) / div(r), "third flow1 sum");
    chk(64'(sum_3b), 64'(fin[3]) / div(r), "third flow2 sum");
    chk(dis_o, 64'(dis_m), "discount");
    chk(sur_o, 64'(sur_m), "surcharge");
  endtask : chk_all
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    #2000000;
    err_count++;
    $display("[FAIL] %0t run limit reached", $time);
    conclude();
  end
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {elec_pulse, min_tick, day_tick, month_tick, year_tick} = '0;
    heat_wh_inc = '0;
    fault = '0;
    void'($urandom(32'h910f8300));
    cfg = '{2'h0, 16'sh1388, 16'($urandom_range(1, 100)), 1'b0, 16'h0001, 5'h05};
    fin = '{0, 0, 0, 0};
    {dis_m, sur_m, th, tp} = '0;
    tick(4);
    chk(64'(days_o), 64'h7, "period in reset");
    tick(4);
    rst <= 1'b0;
    tick(2);
    // random integrations, equal-temperature and reference corners
    for (int i = 0; i < 40; i++) begin
      rand_meas(m);
      if (i == 5) m.outlet_temperature = m.inlet_temperature;
      if (i == 6) m.outlet_temperature = cfg.outlet_reference_temperature;
      integ(m, (i == 39) || 1'($urandom_range(0, 1)));
    end
    for (int r = 0; r < 4; r++) begin
      cfg.vol_res <= 2'(r);
      tick(3);
      chk_all(2'(r));
    end
    $display("test accumulate done");
    // each fault combination freezes its sums
    for (int f = 0; f < 8; f++) begin
      fault <= 3'(f);
      cfg.outlet_reference_temperature <= 16'(4000 + 500 * f);
      tick(1);
      for (int i = 0; i < 3; i++) begin
        rand_meas(m);
        integ(m, 1'b1);
      end
      fault <= '0;
      tick(3);
      chk_all(2'h3);
    end
    $display("test fault done");
    // averaging window clamping
    for (int k = 0; k < 5; k++) begin
      cfg.perf_days <= 5'(k * 7 + 3);
      tick(3);
      chk(64'(days_o), (k == 0) ? 64'h5 : (k == 4) ? 64'h1e : 64'(k * 7 + 3), "period");
    end
    cfg.perf_days <= 5'h05;
    pulse(1);
    $display("test window done");
    // daily coefficient over a five day window
    for (int d = 0; d < 10; d++) begin
      hd[d] = (d >= 7) ? 60000 : $urandom_range(2000, 20000);
      pd[d] = (d >= 7) ? 1 : $urandom_range(1, 3);
      th += hd[d];
      tp += pd[d];
      heat_wh_inc <= 32'(hd[d]);
      fe.send('0, 1'b1);
      heat_wh_inc <= '0;
      tick(1);
      repeat (pd[d]) pulse(0);
      pulse(2);
      tick(1);
      if (d < 4) begin
        chk(64'(perf_now), 64'h0, "coefficient before window full");
      end else begin
        chk(64'(perf_now), 64'(perf_of(hd[d] + hd[d-1] + hd[d-2] + hd[d-3] + hd[d-4],
            1000 * (pd[d] + pd[d-1] + pd[d-2] + pd[d-3] + pd[d-4]))), "current coefficient");
      end
    end
    {month_tick, year_tick, min_tick} <= 3'h7;
    tick(1);
    {month_tick, year_tick, min_tick} <= 3'h0;
    tick(3);
    chk(64'(perf_mon), 64'(perf_of(th, 1000 * tp)), "monthly coefficient");
    chk(64'(perf_yr), 64'(perf_of(th, 1000 * tp)), "seasonal coefficient");
    chk(64'(power_w), 64'(tp * 60000), "current power");
    $display("test coefficient done");
    conclude();
  end
endmodule : mea_accumulators_test
`default_nettype wire
